// ===== dv/spi_master_model.sv
// SPI master model that drives the serial EEPROM link
`timescale 1ns/100ps
module spi_master_model (
  // Serial link
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic hold_n_o,
  output logic si_o
);
  localparam time HALF = 80ns;

  // ----------------------------------------------------------------
  // Idle link: deselected, clock still
  // ----------------------------------------------------------------
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    hold_n_o = 1'b1;
    si_o = 1'b0;
  end

  // One frame: nin bits sent MSB first, then nout bits read back.
  // The clock only runs inside frames; hold_at picks a bit to suspend on when cpol is low.
  task automatic xfer(input logic cpol, input logic [23:0] tx, input int nin,
      input int nout, input int hold_at, output logic [15:0] rx);
    rx = 16'h0000;
    sck_o = cpol;
    #3ns;
    cs_n_o = 1'b0;
    for (int i = 0; i < nin + nout; i++) begin
      // Past the input phase the data line is junk, the device ignores it
      // Data moves just after the edge so it never races the capture flop
      #1ns;
      si_o = (i < nin) ? tx[23 - i] : ~si_o;
      #HALF;
      if (cpol) begin
        if (i >= nin) rx = {rx[14:0], so_i};
        sck_o = 1'b0;
        #HALF;
        sck_o = 1'b1;
      end else begin
        sck_o = 1'b1;
        if (i == hold_at) begin
          // Suspend and resume both while the clock is high
          #40ns;
          hold_n_o = 1'b0;
          si_o = ~si_o;
          #40ns;
          sck_o = 1'b0;
          #HALF;
          sck_o = 1'b1;
          #40ns;
          si_o = ~si_o;
          hold_n_o = 1'b1;
          #40ns;
        end else begin
          #HALF;
        end
        if (i >= nin) rx = {rx[14:0], so_i};
        sck_o = 1'b0;
      end
    end
    #HALF;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #200ns;
  endtask : xfer
endmodule : spi_master_model

// ===== dv/test_serial_eeprom_spi_slave.sv
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fails++; \
  $display("FAIL %0t got %h exp %h", $time, got, exp); end end
module test_serial_eeprom_spi_slave;
  localparam int PROG = 400;
  logic ref_clk_i, rst_n_i, ce_i, wp_n_i, flt;
  logic sck, cs_n, hold_n, si, so_o, so_oe_o;
  logic so_w;
  int fails = 0;
  int n_checks = 0;

  // ----------------------------------------------------------------
  // Clock, reset and the floating data line
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // A released line toggles so a stale bit never passes for data
  initial flt = 1'b0;
  always @(posedge ref_clk_i) flt <= ~flt;
  assign so_w = so_oe_o ? so_o : flt;

  serial_eeprom_spi_slave #(.PROG_CYCLES(PROG)) i_serial_eeprom_spi_slave (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sck_i(sck),
    .cs_n_i(cs_n), .hold_n_i(hold_n), .si_i(si), .so_o(so_o),
    .so_oe_o(so_oe_o), .wp_n_i(wp_n_i));
  spi_master_model i_spi_master_model (.so_i(so_w), .sck_o(sck), .cs_n_o(cs_n),
    .hold_n_o(hold_n), .si_o(si));

  // Output must float whenever deselected or suspended
  always @(negedge ref_clk_i) if (rst_n_i && (cs_n || !hold_n)) `CHK(so_oe_o, 1'b0)

  // ----------------------------------------------------------------
  // Link helpers
  // ----------------------------------------------------------------
  task automatic cmd(input logic [7:0] op, input int n);
    logic [15:0] rx;
    i_spi_master_model.xfer(1'b0, {op, 16'h0000}, n, 0, -1, rx);
  endtask : cmd
  task automatic stat(output logic [7:0] s);
    logic [15:0] rx;
    i_spi_master_model.xfer(1'b0, {eeprom_spi_pkg::OPC_STAT_RD, 16'h0000}, 8, 8, -1, rx);
    s = rx[7:0];
  endtask : stat
  // Poll busy under a bounded count
  task automatic wait_ready;
    logic [7:0] s;
    s = 8'h01;
    for (int k = 0; k < 20 && s[0] !== 1'b0; k++) stat(s);
    `CHK(s[0], 1'b0)
  endtask : wait_ready
  task automatic wr_raw(input logic [8:0] a, input logic [7:0] d);
    logic [15:0] rx;
    i_spi_master_model.xfer(1'b0, {eeprom_spi_pkg::OPC_ARR_WR | {4'h0, a[8], 3'h0},
      a[7:0], d}, 24, 0, -1, rx);
  endtask : wr_raw
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    cmd(eeprom_spi_pkg::OPC_SET_WL, 8);
    wr_raw(a, d);
    wait_ready();
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic cpol, input int hold_at,
      output logic [15:0] rx);
    i_spi_master_model.xfer(cpol, {eeprom_spi_pkg::OPC_ARR_RD | {4'h0, a[8], 3'h0},
      a[7:0], 8'h00}, 16, 16, hold_at, rx);
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_latch;
    logic [7:0] s;
    stat(s);
    `CHK(s[3:0], 4'h0)
    cmd(eeprom_spi_pkg::OPC_SET_WL, 7);
    stat(s);
    `CHK(s[1], 1'b0)
    cmd(eeprom_spi_pkg::OPC_SET_WL, 8);
    stat(s);
    `CHK(s[3:0], 4'h2)
    cmd(eeprom_spi_pkg::OPC_CLR_WL, 8);
    stat(s);
    `CHK(s[3:0], 4'h0)
    $display("test latch done");
  endtask : t_latch

  task automatic t_write;
    logic [7:0] s;
    logic [15:0] rx;
    cmd(eeprom_spi_pkg::OPC_SET_WL, 8);
    wr_raw(9'h000, 8'h3C);
    stat(s);
    `CHK(s[0], 1'b1)
    wait_ready();
    stat(s);
    `CHK(s[1], 1'b0)
    wr(9'h0FF, 8'h5A);
    wr(9'h1FF, 8'hA5);
    rd(9'h1FF, 1'b0, -1, rx);
    `CHK(rx, 16'hA53C)
    rd(9'h0FF, 1'b0, -1, rx);
    `CHK(rx[15:8], 8'h5A)
    $display("test write done");
  endtask : t_write

  task automatic t_refuse;
    logic [15:0] rx;
    wr_raw(9'h000, 8'h77);
    wait_ready();
    rd(9'h000, 1'b0, -1, rx);
    `CHK(rx[15:8], 8'h3C)
    @(negedge ref_clk_i) wp_n_i = 1'b0;
    wr(9'h000, 8'h77);
    rd(9'h000, 1'b0, -1, rx);
    `CHK(rx[15:8], 8'h3C)
    @(negedge ref_clk_i) wp_n_i = 1'b1;
    cmd(eeprom_spi_pkg::OPC_CLR_WL, 8);
    $display("test refuse done");
  endtask : t_refuse

  // Levels 1 to 3: a protected address keeps its value; at levels 1 and 2 one just below takes a write
  task automatic t_prot;
    logic [8:0] bad [3] = '{9'h1FF, 9'h1FF, 9'h000};
    logic [7:0] old [3] = '{8'hA5, 8'hA5, 8'h3C};
    logic [8:0] good [3] = '{9'h17F, 9'h0FF, 9'h000};
    logic [7:0] s;
    logic [15:0] rx;
    for (int lv = 1; lv <= 4; lv++) begin
      cmd(eeprom_spi_pkg::OPC_SET_WL, 8);
      i_spi_master_model.xfer(1'b0, {eeprom_spi_pkg::OPC_STAT_WR, 4'h0, 2'(lv % 4),
        2'h0, 8'h00}, 16, 0, -1, rx);
      wait_ready();
      stat(s);
      `CHK(s[3:2], 2'(lv % 4))
      if (lv < 4) begin
        wr(bad[lv - 1], 8'h99);
        rd(bad[lv - 1], 1'b0, -1, rx);
        `CHK(rx[15:8], old[lv - 1])
        if (lv < 3) begin
          wr(good[lv - 1], 8'(lv));
          rd(good[lv - 1], 1'b0, -1, rx);
          `CHK(rx[15:8], 8'(lv))
        end
      end
    end
    $display("test protection done");
  endtask : t_prot

  task automatic t_mode_hold;
    logic [15:0] rx;
    rd(9'h1FF, 1'b1, -1, rx);
    `CHK(rx, 16'hA53C)
    rd(9'h1FF, 1'b0, 5, rx);
    `CHK(rx, 16'hA53C)
    rd(9'h1FF, 1'b0, 21, rx);
    `CHK(rx, 16'hA53C)
    $display("test mode and hold done");
  endtask : t_mode_hold

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // Whole run needs some 250 us; allow more than three times that
  initial begin
    #900000;
    fails++;
    test_done();
  end

  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    wp_n_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    t_latch();
    t_write();
    t_refuse();
    t_prot();
    t_mode_hold();
    test_done();
  end
endmodule : test_serial_eeprom_spi_slave

// ===== src/eeprom_spi_pkg.sv
// Shared constants and types for the serial EEPROM slave
package eeprom_spi_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Opcodes; array opcodes carry the ninth address bit in bit 3
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_SET_WL = 8'h06;
  localparam logic [7:0] OPC_CLR_WL = 8'h04;
  localparam logic [7:0] OPC_STAT_RD = 8'h05;
  localparam logic [7:0] OPC_STAT_WR = 8'h01;
  localparam logic [7:0] OPC_ARR_RD = 8'h03;
  localparam logic [7:0] OPC_ARR_WR = 8'h02;
  localparam logic [7:0] OPC_ARR_MASK = 8'hF7;
  localparam int OPC_ADDR_HI_BIT = 3;

  // ----------------------------------------------------------------
  // Bit counts within a frame
  // ----------------------------------------------------------------
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] OPC_BITS = 5'h08;
  localparam logic [4:0] ADDR_LAST = 5'h0F;
  localparam logic [4:0] ADDR_END = 5'h10;
  localparam logic [4:0] DATA_LAST = 5'h17;
  localparam logic [4:0] DATA_END = 5'h18;
  localparam logic [4:0] BITS_MAX = 5'h1F;

  // ----------------------------------------------------------------
  // Block protection bases
  // ----------------------------------------------------------------
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_UPQ = 2'h1;
  localparam logic [1:0] PROT_UPH = 2'h2;
  localparam logic [8:0] PROT_UPQ_BASE = 9'h180;
  localparam logic [8:0] PROT_UPH_BASE = 9'h100;
  localparam logic [1:0] PROT_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Programming time
  // ----------------------------------------------------------------
  localparam int T_PROG_MS = 15;
  localparam int REF_PERIOD_NS = 10;
  localparam int PROG_CYCLES_DEF = (T_PROG_MS * 1000000) / REF_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_SET_WL = 3'h1,
    K_CLR_WL = 3'h2,
    K_STAT_RD = 3'h3,
    K_STAT_WR = 3'h4,
    K_ARR_RD = 3'h5,
    K_ARR_WR = 3'h6
  } cmd_kind_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } prog_state_t;

  // Status byte layout, MSB first
  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] prot;
    logic wel;
    logic busy;
  } status_t;

endpackage : eeprom_spi_pkg

// ===== src/serial_eeprom_spi_slave.sv
// Serial EEPROM slave: SPI command logic, protection and array
`timescale 1ns/100ps

// Overview of operation
// - Traffic only while selected and not suspended
// - Input bits captured on falling clock edges
// - Output floats while input bits shift in
// - Read output driven after rising edges
// - Suspend acts at once, whatever the clock level
// - Suspended: ignore clock, float output, resume exactly
// - Resume acts at once, whatever the clock level
// - Suspend low always floats the output at once
// - Both idle-clock polarities work identically
// - Array read: opcode, low address, then data
// - Read auto-increments and wraps the address
// - Status: protection 3:2, latch 1, busy 0
// - Latch bit reads one when write enabled
// - Busy bit reads one while programming
// - During programming only busy bit is valid
// - Status shifted out most significant bit first
// - Write latch clear at power-up
// - Clear command blocks programming until set again
// - Array write needs protect pin high, latch set
// - Writes to protected blocks are refused
// - Opcode decode of the six commands
// - Ninth address bit comes from opcode bit 3
// - Programming starts when select rises after data
// - Finished write cycle clears the latch
module serial_eeprom_spi_slave #(
  parameter int PROG_CYCLES = eeprom_spi_pkg::PROG_CYCLES_DEF
) (
  // System clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Serial link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // Protection pin
  input wire logic wp_n_i
);

  localparam int TMR_W = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic eeprom_spi_pkg::cmd_kind_t decode(input logic [7:0] opc);
    eeprom_spi_pkg::cmd_kind_t k;
    k = eeprom_spi_pkg::K_NONE;
    if (opc == eeprom_spi_pkg::OPC_SET_WL) begin
      k = eeprom_spi_pkg::K_SET_WL;
    end else if (opc == eeprom_spi_pkg::OPC_CLR_WL) begin
      k = eeprom_spi_pkg::K_CLR_WL;
    end else if (opc == eeprom_spi_pkg::OPC_STAT_RD) begin
      k = eeprom_spi_pkg::K_STAT_RD;
    end else if (opc == eeprom_spi_pkg::OPC_STAT_WR) begin
      k = eeprom_spi_pkg::K_STAT_WR;
    end else if ((opc & eeprom_spi_pkg::OPC_ARR_MASK) == eeprom_spi_pkg::OPC_ARR_RD) begin
      k = eeprom_spi_pkg::K_ARR_RD;
    end else if ((opc & eeprom_spi_pkg::OPC_ARR_MASK) == eeprom_spi_pkg::OPC_ARR_WR) begin
      k = eeprom_spi_pkg::K_ARR_WR;
    end
    return k;
  endfunction : decode

  function automatic logic prot_hit(input logic [1:0] lvl, input logic [8:0] a);
    logic hit;
    hit = 1'b1;
    if (lvl == eeprom_spi_pkg::PROT_NONE) begin
      hit = 1'b0;
    end else if (lvl == eeprom_spi_pkg::PROT_UPQ) begin
      hit = (a >= eeprom_spi_pkg::PROT_UPQ_BASE);
    end else if (lvl == eeprom_spi_pkg::PROT_UPH) begin
      hit = (a >= eeprom_spi_pkg::PROT_UPH_BASE);
    end
    return hit;
  endfunction : prot_hit

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  // Command capture on falling clock; kept past deselect for the system side
  typedef struct packed {
    logic tog;
    logic [4:0] bits;
    logic [7:0] sh;
    logic [7:0] opcode;
    logic [8:0] addr;
    logic [7:0] data;
  } cap_t;

  // Output shifter on rising clock; cleared by deselect
  typedef struct packed {
    logic driving;
    logic so;
    logic [7:0] sh;
    logic [2:0] cnt;
  } out_t;

  typedef struct packed {
    eeprom_spi_pkg::status_t meta;
    eeprom_spi_pkg::status_t sync;
  } ssync_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic cs_prev;
  } rsync_t;

  typedef struct packed {
    eeprom_spi_pkg::prog_state_t st;
    logic wel;
    logic [1:0] prot;
    logic seen;
    logic [TMR_W-1:0] tmr;
    logic [8:0] paddr;
    logic [7:0] pdata;
    logic pstat;
  } ctl_t;

  cap_t cap_ff, nxt_cap;
  logic live_ff, nxt_live;
  out_t out_ff, nxt_out;
  ssync_t ss_ff, nxt_ss;
  rsync_t rs_ff, nxt_rs;
  ctl_t ctl_ff, nxt_ctl;
  logic [7:0] mem [0:(1 << eeprom_spi_pkg::ADDR_W)-1];
  logic lnk_rst_n;
  logic out_on;
  logic mem_we;
  logic cs_rise;
  eeprom_spi_pkg::cmd_kind_t cap_kind;
  eeprom_spi_pkg::status_t stat_now;

  // Deselect clears the link-side frame state asynchronously
  assign lnk_rst_n = rst_n_i & ~cs_n_i;
  assign cap_kind = decode(cap_ff.opcode);

  // Output phase starts once the last input bit of a read is in
  assign out_on = live_ff &&
    (((cap_kind == eeprom_spi_pkg::K_ARR_RD) && (cap_ff.bits >= eeprom_spi_pkg::ADDR_END)) ||
     ((cap_kind == eeprom_spi_pkg::K_STAT_RD) && (cap_ff.bits >= eeprom_spi_pkg::OPC_BITS)));

  // ----------------------------------------------------------------
  // Falling edge: shift in opcode, address and data
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] bits_now;
    logic [7:0] shifted;
    bits_now = live_ff ? cap_ff.bits : 5'h00;
    shifted = {cap_ff.sh[6:0], si_i};
    nxt_cap = cap_ff;
    nxt_live = live_ff;
    // Suspension freezes everything, so release resumes in place
    // Edges while deselected are not traffic; they must not flip the frame toggle
    if (hold_n_i && !cs_n_i) begin
      nxt_live = 1'b1;
      if (!live_ff) begin
        nxt_cap.tog = ~cap_ff.tog;
      end
      nxt_cap.sh = shifted;
      nxt_cap.bits = (bits_now == eeprom_spi_pkg::BITS_MAX) ? bits_now : bits_now + 5'h01;
      if (bits_now == eeprom_spi_pkg::OPC_LAST) begin
        nxt_cap.opcode = shifted;
        nxt_cap.addr[8] = shifted[eeprom_spi_pkg::OPC_ADDR_HI_BIT];
      end else if (bits_now >= eeprom_spi_pkg::OPC_BITS) begin
        case (cap_kind)
          eeprom_spi_pkg::K_ARR_RD, eeprom_spi_pkg::K_ARR_WR: begin
            if (bits_now == eeprom_spi_pkg::ADDR_LAST) begin
              nxt_cap.addr[7:0] = shifted;
            end else if (cap_kind == eeprom_spi_pkg::K_ARR_WR &&
                         bits_now == eeprom_spi_pkg::DATA_LAST) begin
              nxt_cap.data = shifted;
            end else if (cap_kind == eeprom_spi_pkg::K_ARR_RD &&
                         bits_now == eeprom_spi_pkg::DATA_LAST) begin
              // Nine-bit add wraps the top location back to zero
              nxt_cap.addr = cap_ff.addr + 9'h001;
              nxt_cap.bits = eeprom_spi_pkg::ADDR_END;
            end
          end
          eeprom_spi_pkg::K_STAT_WR: begin
            if (bits_now == eeprom_spi_pkg::ADDR_LAST) begin
              nxt_cap.data = shifted;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(negedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_ff <= '0;
    end else begin
      cap_ff <= nxt_cap;
    end
  end

  // Frame-live flag, dropped on deselect
  always_ff @(negedge sck_i or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      live_ff <= 1'b0;
    end else begin
      live_ff <= nxt_live;
    end
  end

  // ----------------------------------------------------------------
  // Rising edge: status synchroniser and output shifter
  // ----------------------------------------------------------------
  assign stat_now = '{rsvd: 4'h0, prot: ctl_ff.prot, wel: ctl_ff.wel,
                      busy: (ctl_ff.st == eeprom_spi_pkg::ST_PROG)};

  // Status is quasi-static; the opcode takes eight edges, so two stages settle in time
  always_comb begin
    nxt_ss.meta = stat_now;
    nxt_ss.sync = ss_ff.meta;
  end

  always_ff @(posedge sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_ff <= '0;
    end else begin
      ss_ff <= nxt_ss;
    end
  end

  always_comb begin
    logic [7:0] byte_now;
    nxt_out = out_ff;
    byte_now = ss_ff.sync;
    if (cap_kind == eeprom_spi_pkg::K_ARR_RD) begin
      byte_now = mem[cap_ff.addr];
    end
    // Serial input is not looked at here; output phase ignores it
    if (hold_n_i && out_on) begin
      nxt_out.driving = 1'b1;
      nxt_out.cnt = out_ff.cnt + 3'h1;
      if (out_ff.cnt == 3'h0) begin
        nxt_out.so = byte_now[7];
        nxt_out.sh = {byte_now[6:0], 1'b0};
      end else begin
        nxt_out.so = out_ff.sh[7];
        nxt_out.sh = {out_ff.sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sck_i or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // Enable gated by the pins directly so suspension floats at once
  assign so_oe_o = out_ff.driving & hold_n_i & ~cs_n_i;
  assign so_o = out_ff.so;

  // ----------------------------------------------------------------
  // System side: pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rs = rs_ff;
    if (ce_i) begin
      nxt_rs.meta = {wp_n_i, cs_n_i};
      nxt_rs.sync = rs_ff.meta;
      nxt_rs.cs_prev = rs_ff.sync[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs_ff <= 5'h1F;
    end else begin
      rs_ff <= nxt_rs;
    end
  end

  assign cs_rise = ce_i & rs_ff.sync[0] & ~rs_ff.cs_prev;

  // ----------------------------------------------------------------
  // System side: latch, protection and programming sequencer
  // ----------------------------------------------------------------
  // Capture fields are stable at deselect since the master stops the clock
  always_comb begin
    logic wr_ok;
    eeprom_spi_pkg::status_t wr_stat;
    wr_stat = ctl_ff.pdata;
    nxt_ctl = ctl_ff;
    wr_ok = ctl_ff.wel & rs_ff.sync[1];
    if (ce_i) begin
      case (ctl_ff.st)
        eeprom_spi_pkg::ST_IDLE: begin
          if (cs_rise && (cap_ff.tog != ctl_ff.seen)) begin
            nxt_ctl.seen = cap_ff.tog;
            case (cap_kind)
              eeprom_spi_pkg::K_SET_WL: begin
                if (cap_ff.bits == eeprom_spi_pkg::OPC_BITS) begin
                  nxt_ctl.wel = 1'b1;
                end
              end
              eeprom_spi_pkg::K_CLR_WL: begin
                if (cap_ff.bits == eeprom_spi_pkg::OPC_BITS) begin
                  nxt_ctl.wel = 1'b0;
                end
              end
              eeprom_spi_pkg::K_ARR_WR: begin
                if (cap_ff.bits == eeprom_spi_pkg::DATA_END && wr_ok &&
                    !prot_hit(ctl_ff.prot, cap_ff.addr)) begin
                  nxt_ctl.st = eeprom_spi_pkg::ST_PROG;
                  nxt_ctl.tmr = '0;
                  nxt_ctl.paddr = cap_ff.addr;
                  nxt_ctl.pdata = cap_ff.data;
                  nxt_ctl.pstat = 1'b0;
                end
              end
              eeprom_spi_pkg::K_STAT_WR: begin
                if (cap_ff.bits == eeprom_spi_pkg::ADDR_END && wr_ok) begin
                  nxt_ctl.st = eeprom_spi_pkg::ST_PROG;
                  nxt_ctl.tmr = '0;
                  nxt_ctl.pdata = cap_ff.data;
                  nxt_ctl.pstat = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
        eeprom_spi_pkg::ST_PROG: begin
          // Frames during programming are consumed but have no effect
          if (cs_rise) begin
            nxt_ctl.seen = cap_ff.tog;
          end
          nxt_ctl.tmr = ctl_ff.tmr + TMR_W'(1);
          if (ctl_ff.tmr == TMR_W'(PROG_CYCLES - 1)) begin
            nxt_ctl.st = eeprom_spi_pkg::ST_IDLE;
            nxt_ctl.wel = 1'b0;
            if (ctl_ff.pstat) begin
              nxt_ctl.prot = wr_stat.prot;
            end
          end
        end
        default: begin
          nxt_ctl.st = eeprom_spi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_ff <= '{st: eeprom_spi_pkg::ST_IDLE, wel: 1'b0, prot: eeprom_spi_pkg::PROT_RESET,
                  seen: 1'b0, tmr: '0, paddr: '0, pdata: '0, pstat: 1'b0};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // Array cell written at the end of the programming time
  assign mem_we = ce_i && (ctl_ff.st == eeprom_spi_pkg::ST_PROG) && !ctl_ff.pstat &&
                  (ctl_ff.tmr == TMR_W'(PROG_CYCLES - 1));

  // Array has no reset; contents are whatever was last programmed
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      mem[ctl_ff.paddr] <= ctl_ff.pdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence prog_start_s;
    (ctl_ff.st == eeprom_spi_pkg::ST_IDLE) ##1 (ctl_ff.st == eeprom_spi_pkg::ST_PROG);
  endsequence

  sequence prog_end_s;
    (ctl_ff.st == eeprom_spi_pkg::ST_PROG) ##1 (ctl_ff.st == eeprom_spi_pkg::ST_IDLE);
  endsequence

  hold_float_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !hold_n_i |-> !so_oe_o) else $error("output driven while suspended");

  desel_float_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cs_n_i |-> !so_oe_o) else $error("output driven while deselected");

  latch_auto_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    prog_end_s |-> !ctl_ff.wel) else $error("latch still set after programming");

  clear_cmd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && cs_rise && cap_kind == eeprom_spi_pkg::K_CLR_WL &&
     ctl_ff.st == eeprom_spi_pkg::ST_IDLE &&
     cap_ff.bits == eeprom_spi_pkg::OPC_BITS && cap_ff.tog != ctl_ff.seen)
    |=> !ctl_ff.wel) else $error("clear command left latch set");

  protect_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    prog_start_s |-> $past(rs_ff.sync[1], 1) && $past(ctl_ff.wel, 1))
    else $error("programming began without pin or latch");

  block_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    prog_start_s |-> ctl_ff.pstat || !prot_hit(ctl_ff.prot, ctl_ff.paddr))
    else $error("programming began on a protected address");

  busy_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    prog_start_s |-> stat_now.busy ##1 (stat_now.busy || PROG_CYCLES < 2))
    else $error("busy bit dropped early");

  read_wrap_a: assert property (@(negedge sck_i) disable iff (cs_n_i || !rst_n_i)
    (hold_n_i && live_ff && cap_kind == eeprom_spi_pkg::K_ARR_RD &&
     cap_ff.bits == eeprom_spi_pkg::DATA_LAST)
    |=> cap_ff.addr == 9'($past(cap_ff.addr) + 9'h001))
    else $error("read address did not advance");

  suspend_freeze_a: assert property (@(negedge sck_i) disable iff (cs_n_i || !rst_n_i)
    !hold_n_i |=> cap_ff.bits == $past(cap_ff.bits) && cap_ff.sh == $past(cap_ff.sh))
    else $error("capture moved while suspended");

endmodule : serial_eeprom_spi_slave
